// file: logic/debug_serial_defs.vh
// constants for the debug serial port register block
`ifndef DEBUG_SERIAL_DEFS_VH
`define DEBUG_SERIAL_DEFS_VH

// ==========================================================
// register byte addresses
`define DSP_CONTROL_ADDR    32'hFFFFEE00
`define DSP_MODE_ADDR       32'hFFFFEE04
`define DSP_IRQ_ENABLE_ADDR 32'hFFFFEE08
`define DSP_IRQ_DISABLE_ADDR 32'hFFFFEE0C
`define DSP_IRQ_MASK_ADDR   32'hFFFFEE10
`define DSP_FLAGS_ADDR      32'hFFFFEE14
`define DSP_RX_HOLD_ADDR    32'hFFFFEE18
`define DSP_TX_HOLD_ADDR    32'hFFFFEE1C

// ==========================================================
// control register bits (write-only commands)
`define CTL_RX_RESET        2
`define CTL_TX_RESET        3
`define CTL_RX_ENABLE       4
`define CTL_RX_DISABLE      5
`define CTL_TX_ENABLE       6
`define CTL_TX_DISABLE      7
`define CTL_CLEAR_ERRORS    8

// ==========================================================
// mode register fields
`define MODE_KIND_LSB       9
`define MODE_KIND_MSB       11
`define MODE_TEST_LSB       14
`define MODE_TEST_MSB       15
`define MODE_VALID_MASK     32'h0000CE00
`define MODE_RESET          32'h00000000

// ==========================================================
// shared flag / mask bit positions
`define FLAG_RX_WAITING     0
`define FLAG_TX_FREE        1
`define FLAG_RX_DMA_END     3
`define FLAG_TX_DMA_END     4
`define FLAG_OVERRUN        5
`define FLAG_STOP_ERR       6
`define FLAG_CHECK_ERR      7
`define FLAG_TX_IDLE        9
`define FLAG_TX_DMA_EMPTY   11
`define FLAG_RX_DMA_FULL    12
`define FLAG_DBG_WRITE      30
`define FLAG_DBG_READ       31
`define IRQ_VALID_MASK      32'hC0001AFB
`define IRQ_MASK_RESET      32'h00000000

// ==========================================================
// serial timing
`define CLK_HZ              10000000
`define BAUD_HZ             115200
`define BIT_CYCLES          ((`CLK_HZ) / (`BAUD_HZ))

`endif

// file: logic/debug_serial_port_regs.v
// debug serial port: apb registers, character transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
`include "debug_serial_defs.vh"

module debug_serial_port_regs (
    // clock and reset
    input  wire        clk_i,
    input  wire        nrst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [31:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // dma channel and debug channel levels
    input  wire        rx_dma_end_i,
    input  wire        tx_dma_end_i,
    input  wire        tx_dma_buffer_empty_i,
    input  wire        rx_dma_buffer_full_i,
    input  wire        debug_chan_write_pending_i,
    input  wire        debug_chan_read_pending_i,
    // serial line and interrupt
    input  wire        serial_in_pin_i,
    output reg         serial_out_pin_o,
    output reg         irq_o
);

    // ==========================================================
    // local constants
    localparam integer BIT_LAST = `BIT_CYCLES - 1;
    localparam integer HALF_LAST = (`BIT_CYCLES / 2) - 1;
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_START = 3'h1;
    localparam [2:0] S_DATA  = 3'h2;
    localparam [2:0] S_CHECK = 3'h3;
    localparam [2:0] S_STOP  = 3'h4;

    // check bit value for a character, 1xx means no check bit
    function check_bit;
        input [2:0] kind;
        input [7:0] data;
        begin
            case (kind[1:0])
                2'h0:    check_bit = ^data;
                2'h1:    check_bit = ~(^data);
                2'h2:    check_bit = 1'b0;
                default: check_bit = 1'b1;
            endcase
        end
    endfunction

    // ==========================================================
    // state
    reg [31:0] mode_ff;
    reg [31:0] imr_ff;
    reg        rx_en_ff;
    reg        tx_en_ff;
    reg        rx_wait_ff;
    reg  [7:0] rhr_ff;
    reg        ovr_ff;
    reg        stop_err_ff;
    reg        chk_err_ff;
    reg        thr_full_ff;
    reg  [7:0] thr_ff;
    reg  [2:0] tx_st_ff;
    reg  [6:0] tx_cnt_ff;
    reg  [2:0] tx_bit_ff;
    reg  [7:0] tx_sh_ff;
    reg        tx_line_ff;
    reg  [2:0] rx_st_ff;
    reg  [6:0] rx_cnt_ff;
    reg  [2:0] rx_bit_ff;
    reg  [7:0] rx_sh_ff;
    reg        rx_chk_ff;

    // ==========================================================
    // bus decode
    wire       setup    = psel_i & ~penable_i;
    wire       done     = psel_i & penable_i & pready_o;
    wire       wr       = done & pwrite_i;
    wire       rd       = done & ~pwrite_i;
    wire       a_ctl    = (paddr_i == `DSP_CONTROL_ADDR);
    wire       a_mode   = (paddr_i == `DSP_MODE_ADDR);
    wire       a_ien    = (paddr_i == `DSP_IRQ_ENABLE_ADDR);
    wire       a_idis   = (paddr_i == `DSP_IRQ_DISABLE_ADDR);
    wire       a_imr    = (paddr_i == `DSP_IRQ_MASK_ADDR);
    wire       a_flags  = (paddr_i == `DSP_FLAGS_ADDR);
    wire       a_rhr    = (paddr_i == `DSP_RX_HOLD_ADDR);
    wire       a_thr    = (paddr_i == `DSP_TX_HOLD_ADDR);
    wire       mapped   = a_ctl | a_mode | a_ien | a_idis | a_imr
                        | a_flags | a_rhr | a_thr;
    wire       ctl_wr   = wr & a_ctl;
    wire [2:0] kind     = mode_ff[`MODE_KIND_MSB:`MODE_KIND_LSB];
    wire [1:0] test     = mode_ff[`MODE_TEST_MSB:`MODE_TEST_LSB];
    wire       remote   = (test == 2'h3);
    wire       clr_err  = ctl_wr & pwdata_i[`CTL_CLEAR_ERRORS];
    wire       rhr_rd   = rd & a_rhr;

    // remote loopback takes both ends out of service
    wire       rx_run   = rx_en_ff & ~remote;
    wire       tx_run   = tx_en_ff & ~remote;
    // local loopback feeds the transmitter line back in
    wire       rx_in    = (test == 2'h2) ? tx_line_ff : serial_in_pin_i;

    // ==========================================================
    // flags word
    reg [31:0] flags;
    always @*
    begin
        flags = 32'h00000000;
        flags[`FLAG_RX_WAITING]   = rx_wait_ff;
        flags[`FLAG_TX_FREE]      = tx_en_ff & ~thr_full_ff;
        flags[`FLAG_RX_DMA_END]   = rx_dma_end_i;
        flags[`FLAG_TX_DMA_END]   = tx_dma_end_i;
        flags[`FLAG_OVERRUN]      = ovr_ff;
        flags[`FLAG_STOP_ERR]     = stop_err_ff;
        flags[`FLAG_CHECK_ERR]    = chk_err_ff;
        flags[`FLAG_TX_IDLE]      = tx_en_ff & ~thr_full_ff
                                  & (tx_st_ff == S_IDLE);
        flags[`FLAG_TX_DMA_EMPTY] = tx_dma_buffer_empty_i;
        flags[`FLAG_RX_DMA_FULL]  = rx_dma_buffer_full_i;
        flags[`FLAG_DBG_WRITE]    = debug_chan_write_pending_i;
        flags[`FLAG_DBG_READ]     = debug_chan_read_pending_i;
    end

    // ==========================================================
    // apb slave: no wait states, answer registered
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else if (done)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else if (setup)
        begin
            pready_o  <= 1'b1;
            pslverr_o <= ~mapped;
            if (pwrite_i)
                prdata_o <= 32'h00000000;
            else if (a_mode)
                prdata_o <= mode_ff;
            else if (a_imr)
                prdata_o <= imr_ff;
            else if (a_flags)
                prdata_o <= flags;
            else if (a_rhr)
                prdata_o <= {24'h000000, rhr_ff};
            else
                prdata_o <= 32'h00000000;
        end
    end

    // ==========================================================
    // configuration, mask and enables
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_ff  <= `MODE_RESET;
            imr_ff   <= `IRQ_MASK_RESET;
            rx_en_ff <= 1'b0;
            tx_en_ff <= 1'b0;
            irq_o    <= 1'b0;
        end
        else
        begin
            if (wr & a_mode)
                mode_ff <= pwdata_i & `MODE_VALID_MASK;
            if (wr & a_ien)
                imr_ff <= imr_ff | (pwdata_i & `IRQ_VALID_MASK);
            else if (wr & a_idis)
                imr_ff <= imr_ff & ~pwdata_i;
            if (ctl_wr)
            begin
                if (pwdata_i[`CTL_RX_RESET] | pwdata_i[`CTL_RX_DISABLE])
                    rx_en_ff <= 1'b0;
                else if (pwdata_i[`CTL_RX_ENABLE])
                    rx_en_ff <= 1'b1;
                if (pwdata_i[`CTL_TX_RESET] | pwdata_i[`CTL_TX_DISABLE])
                    tx_en_ff <= 1'b0;
                else if (pwdata_i[`CTL_TX_ENABLE])
                    tx_en_ff <= 1'b1;
            end
            irq_o <= |(flags & imr_ff);
        end
    end

    // ==========================================================
    // output pin select, registered so the pin never glitches
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            serial_out_pin_o <= 1'b1;
        else
        begin
            case (test)
                2'h0:    serial_out_pin_o <= tx_line_ff;
                2'h1:    serial_out_pin_o <= serial_in_pin_i;
                2'h2:    serial_out_pin_o <= 1'b1;
                default: serial_out_pin_o <= serial_in_pin_i;
            endcase
        end
    end

    // ==========================================================
    // transmitter: holding register feeds the shifter
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            thr_full_ff <= 1'b0;
            thr_ff      <= 8'h00;
            tx_st_ff    <= S_IDLE;
            tx_cnt_ff   <= 7'h00;
            tx_bit_ff   <= 3'h0;
            tx_sh_ff    <= 8'h00;
            tx_line_ff  <= 1'b1;
        end
        else if (!tx_run)
        begin
            // disabling aborts; a queued character is dropped
            thr_full_ff <= 1'b0;
            tx_st_ff    <= S_IDLE;
            tx_line_ff  <= 1'b1;
        end
        else
        begin
            if (wr & a_thr)
            begin
                thr_ff      <= pwdata_i[7:0];
                thr_full_ff <= 1'b1;
            end
            if (tx_st_ff == S_IDLE)
            begin
                if (thr_full_ff & ~(wr & a_thr))
                begin
                    tx_sh_ff    <= thr_ff;
                    thr_full_ff <= 1'b0;
                    tx_st_ff    <= S_START;
                    tx_cnt_ff   <= BIT_LAST[6:0];
                    tx_line_ff  <= 1'b0;
                end
            end
            else if (tx_cnt_ff != 7'h00)
                tx_cnt_ff <= tx_cnt_ff - 7'h01;
            else
            begin
                tx_cnt_ff <= BIT_LAST[6:0];
                case (tx_st_ff)
                    S_START:
                    begin
                        tx_st_ff   <= S_DATA;
                        tx_bit_ff  <= 3'h0;
                        tx_line_ff <= tx_sh_ff[0];
                    end
                    S_DATA:
                    begin
                        if (tx_bit_ff != 3'h7)
                        begin
                            tx_bit_ff  <= tx_bit_ff + 3'h1;
                            tx_line_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
                        end
                        else if (!kind[2])
                        begin
                            tx_st_ff   <= S_CHECK;
                            tx_line_ff <= check_bit(kind, tx_sh_ff);
                        end
                        else
                        begin
                            tx_st_ff   <= S_STOP;
                            tx_line_ff <= 1'b1;
                        end
                    end
                    S_CHECK:
                    begin
                        tx_st_ff   <= S_STOP;
                        tx_line_ff <= 1'b1;
                    end
                    default:
                    begin
                        tx_st_ff   <= S_IDLE;
                        tx_line_ff <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // receiver: mid-bit sampling, no glitch filter
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_st_ff    <= S_IDLE;
            rx_cnt_ff   <= 7'h00;
            rx_bit_ff   <= 3'h0;
            rx_sh_ff    <= 8'h00;
            rx_chk_ff   <= 1'b0;
            rhr_ff      <= 8'h00;
            rx_wait_ff  <= 1'b0;
            ovr_ff      <= 1'b0;
            stop_err_ff <= 1'b0;
            chk_err_ff  <= 1'b0;
        end
        else
        begin
            // clear first, so a same-cycle event below wins
            if (clr_err)
            begin
                ovr_ff      <= 1'b0;
                stop_err_ff <= 1'b0;
                chk_err_ff  <= 1'b0;
            end
            if (rhr_rd | ~rx_run)
                rx_wait_ff <= 1'b0;
            if (!rx_run)
                rx_st_ff <= S_IDLE;
            else if (rx_st_ff == S_IDLE)
            begin
                if (!rx_in)
                begin
                    rx_st_ff  <= S_START;
                    rx_cnt_ff <= HALF_LAST[6:0];
                end
            end
            else if (rx_cnt_ff != 7'h00)
                rx_cnt_ff <= rx_cnt_ff - 7'h01;
            else
            begin
                rx_cnt_ff <= BIT_LAST[6:0];
                case (rx_st_ff)
                    S_START:
                    begin
                        rx_bit_ff <= 3'h0;
                        rx_st_ff  <= rx_in ? S_IDLE : S_DATA;
                    end
                    S_DATA:
                    begin
                        rx_sh_ff  <= {rx_in, rx_sh_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'h7)
                            rx_st_ff <= kind[2] ? S_STOP : S_CHECK;
                    end
                    S_CHECK:
                    begin
                        rx_chk_ff <= rx_in ^ check_bit(kind, rx_sh_ff);
                        rx_st_ff  <= S_STOP;
                    end
                    default:
                    begin
                        rx_st_ff   <= S_IDLE;
                        rhr_ff     <= rx_sh_ff;
                        rx_wait_ff <= 1'b1;
                        if (rx_wait_ff & ~rhr_rd)
                            ovr_ff <= 1'b1;
                        if (!rx_in)
                            stop_err_ff <= 1'b1;
                        if (!kind[2] & rx_chk_ff)
                            chk_err_ff <= 1'b1;
                        rx_chk_ff  <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // debug_serial_port_regs

`default_nettype wire

// file: testbench/debug_serial_monitor.sv
// assertion checker bound to the debug serial port register block
`timescale 1ns/1ps
`default_nettype none
`include "debug_serial_defs.vh"

module debug_serial_monitor (
    // clock, reset and apb
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // levels shown live in the flags register
    input wire logic        rx_dma_end_i,
    input wire logic        tx_dma_end_i,
    input wire logic        tx_dma_buffer_empty_i,
    input wire logic        rx_dma_buffer_full_i,
    input wire logic        debug_chan_write_pending_i,
    input wire logic        debug_chan_read_pending_i
);
    // ==========================================================
    // flags read completing; levels were taken at the setup edge
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic rd_flags;
    assign rd_flags = pready_o && !pwrite_i && paddr_i == `DSP_FLAGS_ADDR;

    a_setup_answered: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_unmapped_err: assert property (pready_o && (paddr_i[1:0] != 2'h0
        || paddr_i[31:5] != 27'h7FFFF70) |-> pslverr_o)
        else $error("unmapped access not refused");
    a_rx_dma_end: assert property (rd_flags |->
        prdata_o[3] == $past(rx_dma_end_i)) else $error("rx end flag");
    a_tx_dma_end: assert property (rd_flags |->
        prdata_o[4] == $past(tx_dma_end_i)) else $error("tx end flag");
    a_dma_buffers: assert property (rd_flags |->
        prdata_o[11] == $past(tx_dma_buffer_empty_i)
        && prdata_o[12] == $past(rx_dma_buffer_full_i))
        else $error("dma buffer flags");
    a_debug_chan: assert property (rd_flags |->
        prdata_o[30] == $past(debug_chan_write_pending_i)
        && prdata_o[31] == $past(debug_chan_read_pending_i))
        else $error("debug channel flags");
    a_flags_reserved: assert property (rd_flags |->
        (prdata_o & ~`IRQ_VALID_MASK) == 32'h0)
        else $error("reserved flag bit set");
endmodule // debug_serial_monitor

bind debug_serial_port_regs debug_serial_monitor u_monitor (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rx_dma_end_i(rx_dma_end_i), .tx_dma_end_i(tx_dma_end_i),
    .tx_dma_buffer_empty_i(tx_dma_buffer_empty_i),
    .rx_dma_buffer_full_i(rx_dma_buffer_full_i),
    .debug_chan_write_pending_i(debug_chan_write_pending_i),
    .debug_chan_read_pending_i(debug_chan_read_pending_i)
);
`default_nettype wire

// file: testbench/serial_terminal_model.sv
// serial terminal model on the far side of the debug serial port
`timescale 1ns/1ps
`default_nettype none

module serial_terminal_model #(
    parameter int BIT_T = 86
) (
    input  wire logic clk_i,
    input  wire logic line_in_i,
    output var  logic line_out_o
);
    // ==========================================================
    // line driving; idle rests high like a pulled-up line
    initial line_out_o = 1'h1;
    task automatic level(input logic b);
        @(posedge clk_i);
        line_out_o <= b;
    endtask
    // start bit then ten frame bits, lsb first
    task automatic send(input logic [9:0] f);
        level(1'h0);
        repeat (BIT_T - 1) @(posedge clk_i);
        for (int i = 0; i < 10; i++)
        begin
            level(f[i]);
            repeat (BIT_T - 1) @(posedge clk_i);
        end
        level(1'h1);
    endtask
    // ==========================================================
    // mid-bit sampling; returns inside the stop bit
    task automatic recv(input int n, output logic [9:0] got);
        int w;
        got = 10'h0;
        for (w = 0; w < 4000 && line_in_i !== 1'h0; w++) @(posedge clk_i);
        repeat (BIT_T / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            repeat (BIT_T) @(posedge clk_i);
            got[i] = line_in_i;
        end
    endtask
endmodule // serial_terminal_model
`default_nettype wire

// file: testbench/testbench.sv
// self-checking testbench for the debug serial port register block
`timescale 1ns/1ps
`default_nettype none
`include "debug_serial_defs.vh"

module testbench;
    // ==========================================================
    // signals and instances
    logic        clk, nrst, psel, pen, pwr, prdy, perr, sin, sout, irq, err;
    logic [31:0] pa, pwd, prd, rd;
    logic [5:0]  lv;
    logic [9:0]  got;
    int          mismatches = 0;
    int          compares = 0;

    debug_serial_port_regs DUT (
        .clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .rx_dma_end_i(lv[0]),
        .tx_dma_end_i(lv[1]), .tx_dma_buffer_empty_i(lv[2]),
        .rx_dma_buffer_full_i(lv[3]), .debug_chan_write_pending_i(lv[4]),
        .debug_chan_read_pending_i(lv[5]), .serial_in_pin_i(sin),
        .serial_out_pin_o(sout), .irq_o(irq)
    );
    serial_terminal_model term (
        .clk_i(clk), .line_in_i(sout), .line_out_o(sin)
    );
    always #50 clk = ~clk;

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one transfer; never assumes the answer delay
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk);
        while (prdy !== 1'h1 && ++n < 16);
        check(prdy, 1'h1);
        rd = prd;
        err = perr;
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk);
    endtask
    function automatic logic [9:0] frame(input logic [7:0] d,
                                         input logic [2:0] k);
        return k[2] ? {2'h1, d} : {1'h1, (k[1] ? k[0] : ^d ^ k[0]), d};
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset;
        apb(0, `DSP_MODE_ADDR, 32'h0);
        check(rd, `MODE_RESET);
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(0, `DSP_TX_HOLD_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1, 32'hFFFFEE24, 32'hFFFFFFFF);
        check(err, 1'h1);
        $display("reset test done");
    endtask
    task automatic t_irq;
        apb(1, `DSP_IRQ_ENABLE_ADDR, 32'hFFFFFFFF);
        apb(0, `DSP_IRQ_MASK_ADDR, 32'h0);
        check(rd, `IRQ_VALID_MASK);
        check(irq, 1'h0);
        lv <= 6'h10;
        repeat (3) @(posedge clk);
        check(irq, 1'h1);
        apb(1, `DSP_IRQ_DISABLE_ADDR, 32'h40000000);
        apb(1, `DSP_IRQ_ENABLE_ADDR, 32'h0);
        apb(0, `DSP_IRQ_MASK_ADDR, 32'h0);
        check(rd, 32'h80001AFB);
        check(irq, 1'h0);
        apb(1, `DSP_IRQ_DISABLE_ADDR, 32'hFFFFFFFF);
        $display("interrupt mask test done");
    endtask
    task automatic t_levels;
        int pos[6] = '{3, 4, 11, 12, 30, 31};
        for (int i = 0; i < 6; i++)
        begin
            lv <= 6'h1 << i;
            apb(0, `DSP_FLAGS_ADDR, 32'h0);
            check(rd, 32'h1 << pos[i]);
        end
        lv <= 6'h0;
        $display("level flags test done");
    endtask
    task automatic t_tx;
        logic [7:0] d;
        apb(1, `DSP_CONTROL_ADDR, 32'h50);
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd, 32'h202);
        for (int k = 0; k < 5; k++)
        begin
            d = 8'hA5 ^ 8'(k);
            apb(1, `DSP_MODE_ADDR, ~`MODE_VALID_MASK | (k << 9));
            apb(0, `DSP_MODE_ADDR, 32'h0);
            check(rd, k << 9);
            fork
                apb(1, `DSP_TX_HOLD_ADDR, {24'h0, d});
                term.recv(k < 4 ? 10 : 9, got);
            join
            check(got, frame(d, 3'(k)));
            repeat (100) @(posedge clk);
        end
        $display("check bit kinds test done");
    endtask
    task automatic t_queue;
        apb(1, `DSP_MODE_ADDR, 32'h0);
        fork
            begin
                apb(1, `DSP_TX_HOLD_ADDR, 32'h3C);
                apb(1, `DSP_TX_HOLD_ADDR, 32'hC3);
                apb(0, `DSP_FLAGS_ADDR, 32'h0);
                check(rd & 32'h202, 32'h0);
            end
            begin
                term.recv(10, got);
                check(got, frame(8'h3C, 3'h0));
                term.recv(10, got);
                check(got, frame(8'hC3, 3'h0));
            end
        join
        repeat (100) @(posedge clk);
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd & 32'h202, 32'h202);
        $display("queued character test done");
    endtask
    task automatic t_rx;
        term.send(frame(8'h5A, 3'h0));
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd & 32'hE1, 32'h1);
        apb(0, `DSP_RX_HOLD_ADDR, 32'h0);
        check(rd, 32'h5A);
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd & 32'hE1, 32'h0);
        term.send(frame(8'h11, 3'h0) ^ 10'h100);
        term.send(frame(8'h22, 3'h0) ^ 10'h200);
        // a low stop bit may look like a start: let it run out
        repeat (1000) @(posedge clk);
        term.send(frame(8'h33, 3'h0));
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd & 32'hE1, 32'hE1);
        apb(1, `DSP_CONTROL_ADDR, 32'h100);
        apb(0, `DSP_FLAGS_ADDR, 32'h0);
        check(rd & 32'hE1, 32'h1);
        apb(0, `DSP_RX_HOLD_ADDR, 32'h0);
        check(rd, 32'h33);
        $display("receive errors test done");
    endtask
    task automatic t_loop;
        logic hi;
        hi = 1'h1;
        apb(1, `DSP_MODE_ADDR, 32'h8000);
        term.level(1'h0);
        apb(1, `DSP_TX_HOLD_ADDR, 32'h96);
        repeat (1100) @(posedge clk) hi = hi & (sout === 1'h1);
        check(hi, 1'h1);
        apb(0, `DSP_RX_HOLD_ADDR, 32'h0);
        check(rd, 32'h96);
        for (int m = 1; m < 4; m += 2)
        begin
            apb(1, `DSP_MODE_ADDR, m << 14);
            for (int b = 0; b < 2; b++)
            begin
                term.level(b[0]);
                repeat (4) @(posedge clk);
                check(sout, b);
            end
        end
        $display("test modes done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        clk = 1'h0;
        {nrst, psel, pen, pwr, pa, pwd, lv} = '0;
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        t_reset;
        t_irq;
        t_levels;
        t_tx;
        t_queue;
        t_rx;
        t_loop;
        stop_test;
    end
    initial
    begin
        #4000000;
        mismatches++;
        stop_test;
    end
endmodule // testbench
`default_nettype wire
